// ### hdl/pcc_pkg.sv
`default_nettype none
package pcc_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_COUNTER_CTRL = 16'h001B;
    localparam logic [15:0] IDX_GAP_CONFIG = 16'h061B;
    localparam logic [15:0] IDX_BYTE_TOTAL = 16'h061C;
    localparam logic [15:0] IDX_PKT_TOTAL_LOW = 16'h061D;
    localparam logic [15:0] IDX_PKT_TOTAL_HIGH = 16'h061E;
    localparam logic [15:0] IDX_MODE_CONFIG = 16'h0600;

    // counter-control bit positions
    localparam int BIT_BYTE_LOCK = 0;
    localparam int BIT_BYTE_LOCK_CLEAR = 1;
    localparam int BIT_PKT_LOCK = 14;
    localparam int BIT_PKT_LOCK_CLEAR = 15;

    // mode-config bit position: 0 single, 1 continuous
    localparam int BIT_CNT_MODE = 0;

    // field widths
    localparam int GAP_WIDTH = 8;
    localparam int BYTE_CNT_WIDTH = 16;
    localparam int PKT_CNT_WIDTH = 32;

    // reset values
    localparam logic [7:0] RST_GAP_LEN = 8'h7D;
    localparam logic [15:0] RST_TOTAL = 16'h0000;
    localparam logic RST_CNT_MODE = 1'b0;

    // terminal values of the tallies
    localparam logic [15:0] BYTE_TERMINAL = 16'hFFFF;
    localparam logic [31:0] PKT_TERMINAL = 32'h0FFFFFFF;

    // bus wait cycles before the answer
    localparam int BUS_WAIT_CYCLES = 1;
endpackage
`default_nettype wire

// ### hdl/pcc_tally.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_tally #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] TERMINAL = '1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic clear,
    input wire logic cont_mode,
    output logic [WIDTH-1:0] count,
    output logic wrap_pulse
);
    logic at_end;

    assign at_end = (count == TERMINAL);

    // tally: clear first, then hold or wrap at terminal value
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
        end
        else if (clear)
        begin
            count <= '0;
        end
        else if (inc)
        begin
            if (!at_end)
            begin
                count <= count + WIDTH'(1);
            end
            else if (cont_mode)
            begin
                count <= '0;
            end
            // single mode holds at the terminal value
        end
    end

    // one-cycle pulse when wrapping in continuous mode
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrap_pulse <= 1'b0;
        end
        else
        begin
            wrap_pulse <= inc && !clear && at_end && cont_mode;
        end
    end
endmodule // pcc_tally
`default_nettype wire

// ### hdl/pcc_gap.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_gap #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] gap_len,
    input wire logic pkt_end,
    input wire logic byte_tick,
    output logic gap_active
);
    typedef enum logic {PCC_GAP_IDLE, PCC_GAP_RUN} pcc_gap_e;

    pcc_gap_e state;
    logic [WIDTH-1:0] remain;

    // idle gap of gap_len byte times after each generated packet
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= PCC_GAP_IDLE;
            remain <= '0;
        end
        else
        begin
            case (state)
                PCC_GAP_IDLE:
                begin
                    if (pkt_end && gap_len != '0)
                    begin
                        state <= PCC_GAP_RUN;
                        remain <= gap_len;
                    end
                end
                PCC_GAP_RUN:
                begin
                    if (byte_tick)
                    begin
                        remain <= remain - WIDTH'(1);
                        if (remain == WIDTH'(1))
                        begin
                            state <= PCC_GAP_IDLE;
                        end
                    end
                end
                default:
                begin
                    state <= PCC_GAP_IDLE;
                end
            endcase
        end
    end

    assign gap_active = (state == PCC_GAP_RUN);
endmodule // pcc_gap
`default_nettype wire

// ### hdl/pcc_top.sv
// Functional notes
// - generated packets separated by programmable byte gap
// - sixteen-bit read-only received byte tally
// - control bits 0 or 1 freeze byte tally
// - single mode: byte tally stops at FFFF
// - 32-bit packet tally in two halves
// - control bits 15 or 14 freeze packet tally
// - single mode: packet tally stops at terminal
// - tally registers read zero after reset
// - continuous mode: pulse and wrap to zero
// - bit 1 freezes and clears, bit 0 freezes
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcc_top #(
    parameter int GAP_WIDTH = pcc_pkg::GAP_WIDTH
) (
    input wire logic clock,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // checker side
    input wire logic rx_byte_valid,
    input wire logic rx_pkt_done,
    // generator side and tally wrap pulses
    input wire logic tx_pkt_end,
    input wire logic tx_byte_tick,
    output logic tx_gap_active,
    output logic byte_wrap_pulse,
    output logic pkt_wrap_pulse
);
    logic ack;
    logic req;
    logic wr_take;
    logic [13:0] idx;
    logic [GAP_WIDTH-1:0] gap_len;
    logic cnt_mode;
    logic byte_lock;
    logic byte_clear;
    logic pkt_lock;
    logic pkt_clear;
    logic [15:0] byte_live;
    logic [31:0] pkt_live;
    logic [15:0] byte_total;
    logic [15:0] pkt_total_low;
    logic [15:0] pkt_total_high;
    logic [31:0] next_readdata;

    // one wait cycle, then the request is taken
    assign req = read || write;
    assign waitrequest = req && !ack;
    assign wr_take = write && ack;
    assign idx = address[15:2];

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack <= 1'b0;
        end
        else
        begin
            ack <= req && !ack;
        end
    end

    // write pulses from the counter-control register
    always_comb
    begin
        byte_lock = 1'b0;
        byte_clear = 1'b0;
        pkt_lock = 1'b0;
        pkt_clear = 1'b0;
        if (wr_take && idx == 14'(pcc_pkg::IDX_COUNTER_CTRL))
        begin
            byte_lock = byteenable[0]
                && (writedata[pcc_pkg::BIT_BYTE_LOCK]
                || writedata[pcc_pkg::BIT_BYTE_LOCK_CLEAR]);
            byte_clear = byteenable[0]
                && writedata[pcc_pkg::BIT_BYTE_LOCK_CLEAR];
            pkt_lock = byteenable[1]
                && (writedata[pcc_pkg::BIT_PKT_LOCK]
                || writedata[pcc_pkg::BIT_PKT_LOCK_CLEAR]);
            pkt_clear = byteenable[1]
                && writedata[pcc_pkg::BIT_PKT_LOCK_CLEAR];
        end
    end

    // gap length and count mode configuration
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_len <= GAP_WIDTH'(pcc_pkg::RST_GAP_LEN);
            cnt_mode <= pcc_pkg::RST_CNT_MODE;
        end
        else if (wr_take && byteenable[0])
        begin
            if (idx == 14'(pcc_pkg::IDX_GAP_CONFIG))
            begin
                gap_len <= writedata[GAP_WIDTH-1:0];
            end
            if (idx == 14'(pcc_pkg::IDX_MODE_CONFIG))
            begin
                cnt_mode <= writedata[pcc_pkg::BIT_CNT_MODE];
            end
        end
    end

    // live tallies
    pcc_tally #(
        .WIDTH(pcc_pkg::BYTE_CNT_WIDTH),
        .TERMINAL(pcc_pkg::BYTE_TERMINAL)
    ) u_byte_tally (
        .clock(clock),
        .rst_n(rst_n),
        .inc(rx_byte_valid),
        .clear(byte_clear),
        .cont_mode(cnt_mode),
        .count(byte_live),
        .wrap_pulse(byte_wrap_pulse)
    );

    pcc_tally #(
        .WIDTH(pcc_pkg::PKT_CNT_WIDTH),
        .TERMINAL(pcc_pkg::PKT_TERMINAL)
    ) u_pkt_tally (
        .clock(clock),
        .rst_n(rst_n),
        .inc(rx_pkt_done),
        .clear(pkt_clear),
        .cont_mode(cnt_mode),
        .count(pkt_live),
        .wrap_pulse(pkt_wrap_pulse)
    );

    // byte snapshot taken from the live tally before any clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            byte_total <= pcc_pkg::RST_TOTAL;
        end
        else if (byte_lock)
        begin
            byte_total <= byte_live;
        end
    end

    // packet snapshot, both halves together
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pkt_total_low <= pcc_pkg::RST_TOTAL;
            pkt_total_high <= pcc_pkg::RST_TOTAL;
        end
        else if (pkt_lock)
        begin
            pkt_total_low <= pkt_live[15:0];
            pkt_total_high <= pkt_live[31:16];
        end
    end

    // read mux; unmapped and control addresses read zero
    always_comb
    begin
        next_readdata = 32'h00000000;
        if (idx == 14'(pcc_pkg::IDX_GAP_CONFIG))
        begin
            next_readdata[GAP_WIDTH-1:0] = gap_len;
        end
        else if (idx == 14'(pcc_pkg::IDX_MODE_CONFIG))
        begin
            next_readdata[pcc_pkg::BIT_CNT_MODE] = cnt_mode;
        end
        else if (idx == 14'(pcc_pkg::IDX_BYTE_TOTAL))
        begin
            next_readdata[15:0] = byte_total;
        end
        else if (idx == 14'(pcc_pkg::IDX_PKT_TOTAL_LOW))
        begin
            next_readdata[15:0] = pkt_total_low;
        end
        else if (idx == 14'(pcc_pkg::IDX_PKT_TOTAL_HIGH))
        begin
            next_readdata[15:0] = pkt_total_high;
        end
    end

    // read data loaded in the wait cycle, stands at the taking edge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            readdata <= 32'h00000000;
        end
        else if (read && !ack)
        begin
            readdata <= next_readdata;
        end
    end

    // inter-packet gap timer
    pcc_gap #(
        .WIDTH(GAP_WIDTH)
    ) u_gap (
        .clock(clock),
        .rst_n(rst_n),
        .gap_len(gap_len),
        .pkt_end(tx_pkt_end),
        .byte_tick(tx_byte_tick),
        .gap_active(tx_gap_active)
    );
endmodule // pcc_top
`default_nettype wire

// ### verif/pcc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic rx_byte_valid,
    input wire logic rx_pkt_done,
    input wire logic tx_pkt_end,
    input wire logic tx_byte_tick,
    input wire logic tx_gap_active,
    input wire logic byte_wrap_pulse,
    input wire logic pkt_wrap_pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // one wait cycle, then the answer
    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    a_read_wait: assert property ($rose(read) |-> s_one_wait)
        else $error("read wait wrong");
    a_write_wait: assert property ($rose(write) |-> s_one_wait)
        else $error("write wait wrong");
    a_idle_ready: assert property (!(read || write) |-> !waitrequest)
        else $error("wait without request");
    a_upper_zero: assert property (readdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_gap_cause: assert property ($rose(tx_gap_active) |-> $past(tx_pkt_end))
        else $error("gap without packet end");
    a_gap_close: assert property ($fell(tx_gap_active) |-> $past(tx_byte_tick))
        else $error("gap ended without tick");
    a_byte_wrap: assert property (byte_wrap_pulse
        |-> $past(rx_byte_valid) ##1 !byte_wrap_pulse)
        else $error("byte wrap pulse wrong");
    a_pkt_wrap: assert property (pkt_wrap_pulse
        |-> $past(rx_pkt_done) ##1 !pkt_wrap_pulse)
        else $error("packet wrap pulse wrong");
endmodule // pcc_assertions
bind pcc_top pcc_assertions u_chk (.clock(clock), .rst_n(rst_n),
    .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .rx_byte_valid(rx_byte_valid),
    .rx_pkt_done(rx_pkt_done), .tx_pkt_end(tx_pkt_end),
    .tx_byte_tick(tx_byte_tick), .tx_gap_active(tx_gap_active),
    .byte_wrap_pulse(byte_wrap_pulse), .pkt_wrap_pulse(pkt_wrap_pulse));
`default_nettype wire

// ### verif/pcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_top_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] address = 16'h0000;
    logic [3:0] byteenable = 4'hF;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest;
    logic rx_byte_valid = 1'b0;
    logic rx_pkt_done = 1'b0;
    logic tx_pkt_end = 1'b0;
    logic tx_byte_tick = 1'b0;
    logic tx_gap_active;
    logic byte_wrap_pulse;
    logic pkt_wrap_pulse;
    logic seen_wrap = 1'b0;
    logic seen_pkt_wrap = 1'b0;
    logic [31:0] q;
    int failures = 0;
    int compares = 0;
    // 10 MHz clock
    always #50 clock = ~clock;
    pcc_top dut (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rx_byte_valid(rx_byte_valid),
        .rx_pkt_done(rx_pkt_done), .tx_pkt_end(tx_pkt_end),
        .tx_byte_tick(tx_byte_tick), .tx_gap_active(tx_gap_active),
        .byte_wrap_pulse(byte_wrap_pulse), .pkt_wrap_pulse(pkt_wrap_pulse));
    // sticky record of byte and packet wrap pulses
    always @(posedge clock)
    begin
        if (byte_wrap_pulse === 1'b1)
            seen_wrap <= 1'b1;
        if (pkt_wrap_pulse === 1'b1)
            seen_pkt_wrap <= 1'b1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one transfer, held until waitrequest is low
    task bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
        @(posedge clock);
        address <= {idx[13:0], 2'b00};
        writedata <= d;
        write <= w;
        read <= !w;
        @(posedge clock);
        while (waitrequest !== 1'b0)
            @(posedge clock);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task rd(input logic [15:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h00000000);
        chk(q, exp);
    endtask
    // n checker bytes or packets on consecutive edges
    task feed(input int n, input logic pkt);
        @(posedge clock);
        rx_byte_valid <= !pkt;
        rx_pkt_done <= pkt;
        repeat (n) @(posedge clock);
        rx_byte_valid <= 1'b0;
        rx_pkt_done <= 1'b0;
    endtask
    task test_regs;
        rd(pcc_pkg::IDX_BYTE_TOTAL, 32'h0);
        rd(pcc_pkg::IDX_PKT_TOTAL_LOW, 32'h0);
        rd(pcc_pkg::IDX_PKT_TOTAL_HIGH, 32'h0);
        rd(pcc_pkg::IDX_GAP_CONFIG, 32'h7D);
        bus(1'b1, pcc_pkg::IDX_GAP_CONFIG, 32'hABCD);
        rd(pcc_pkg::IDX_GAP_CONFIG, 32'hCD);
        // write with lane 0 off must leave the gap length alone
        byteenable <= 4'hE;
        bus(1'b1, pcc_pkg::IDX_GAP_CONFIG, 32'h11);
        byteenable <= 4'hF;
        rd(pcc_pkg::IDX_GAP_CONFIG, 32'hCD);
        bus(1'b1, pcc_pkg::IDX_BYTE_TOTAL, 32'h1234);
        rd(pcc_pkg::IDX_BYTE_TOTAL, 32'h0);
        rd(16'h0123, 32'h0);
        $display("register test done");
    endtask
    task test_gap;
        bus(1'b1, pcc_pkg::IDX_GAP_CONFIG, 32'h02);
        @(posedge clock) tx_pkt_end <= 1'b1;
        @(posedge clock)
        begin
            tx_pkt_end <= 1'b0;
            tx_byte_tick <= 1'b1;
        end
        @(negedge clock) chk(tx_gap_active, 1);
        @(posedge clock);
        @(negedge clock) chk(tx_gap_active, 1);
        @(posedge clock) tx_byte_tick <= 1'b0;
        @(negedge clock) chk(tx_gap_active, 0);
        $display("gap test done");
    endtask
    task test_counts;
        feed(5, 1'b0);
        feed(3, 1'b1);
        bus(1'b1, pcc_pkg::IDX_COUNTER_CTRL, 32'h1);
        rd(pcc_pkg::IDX_BYTE_TOTAL, 32'h5);
        rd(pcc_pkg::IDX_PKT_TOTAL_LOW, 32'h0);
        feed(3, 1'b0);
        bus(1'b1, pcc_pkg::IDX_COUNTER_CTRL, 32'h2);
        rd(pcc_pkg::IDX_BYTE_TOTAL, 32'h8);
        bus(1'b1, pcc_pkg::IDX_COUNTER_CTRL, 32'h1);
        rd(pcc_pkg::IDX_BYTE_TOTAL, 32'h0);
        bus(1'b1, pcc_pkg::IDX_COUNTER_CTRL, 32'h4000);
        rd(pcc_pkg::IDX_PKT_TOTAL_LOW, 32'h3);
        rd(pcc_pkg::IDX_PKT_TOTAL_HIGH, 32'h0);
        bus(1'b1, pcc_pkg::IDX_COUNTER_CTRL, 32'h8000);
        bus(1'b1, pcc_pkg::IDX_COUNTER_CTRL, 32'h4000);
        rd(pcc_pkg::IDX_PKT_TOTAL_LOW, 32'h0);
        $display("count test done");
    endtask
    task test_limit;
        feed(65537, 1'b0);
        bus(1'b1, pcc_pkg::IDX_COUNTER_CTRL, 32'h1);
        rd(pcc_pkg::IDX_BYTE_TOTAL, 32'hFFFF);
        chk({31'h0, seen_wrap}, 32'h0);
        bus(1'b1, pcc_pkg::IDX_MODE_CONFIG, 32'h1);
        feed(1, 1'b0);
        bus(1'b1, pcc_pkg::IDX_COUNTER_CTRL, 32'h1);
        rd(pcc_pkg::IDX_BYTE_TOTAL, 32'h0);
        chk({31'h0, seen_wrap}, 32'h1);
        chk({31'h0, seen_pkt_wrap}, 32'h0);
        $display("limit test done");
    endtask
    task print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        test_regs;
        test_gap;
        test_counts;
        test_limit;
        print_verdict;
    end
    // watchdog, well past the expected run
    initial
    begin
        #(100 * 90000);
        failures++;
        print_verdict;
    end
endmodule // pcc_top_tb
`default_nettype wire
